// ==== dlc_consts.vh ====
// Operation
// - Bit 5 of converter control picks bypass encoding: 0 offset binary, 1 two's complement.
// - Any decimating mode always emits two's complement samples regardless of bit 5.
// - Bit 4 sets final filter gain: 0 unity, 1 boost of 6.02 dB, default set.
// - Decimation field: 0 bypass, 2..7 divide 4,8,10,16,20,32; others reserved.
// - Bit 7 of link control A enables whitening; off after reset.
// - Bits 6..2 of link control A hold frames per multiframe minus one, reset 3.
// - Bit 1 of link control A: 0 bit rate equals sample clock, 1 double, default.
// - Link enable clear holds link in reset, serializers down, clocks gated.
// - Bit 7 of link control B enables five-fourths PLL: rate 1.25x or 2.5x.
// - Bit 6 of link control B picks sync source: 0 single-ended, 1 differential.
// - Test field: 0 normal, 1..9 PRBS, ramp, transport, D21.5, K28.5, alignment, RPAT.
// - Test code 10 holds outputs low, 11 high, 12..15 reserved.
// - Identifier byte is sent in second multiframe of initial lane alignment.
`ifndef DLC_CONSTS_VH
`define DLC_CONSTS_VH
`define DLC_OFF_DDC 10'h200
`define DLC_OFF_LNKA 10'h201
`define DLC_OFF_LNKB 10'h202
`define DLC_OFF_DID 10'h203
`define DLC_OFF_LNKC 10'h204
`define DLC_RST_DDC 8'h10
`define DLC_RST_LNKA 8'h0F
`define DLC_RST_LNKB 8'h00
`define DLC_RST_DID 8'h00
`define DLC_RST_LNKC 8'h00
`define DLC_BIT_ENC 5
`define DLC_BIT_BOOST 4
`define DLC_BIT_WHITEN 7
`define DLC_BIT_DDR 1
`define DLC_BIT_LEN 0
`define DLC_BIT_P54 7
`define DLC_BIT_SYNCSEL 6
`define DLC_DDC_MASK 8'h3F
`define DLC_LNKB_MASK 8'hCF
`define DLC_LNKC_MASK 8'h03
`define DLC_TEST_LOW 4'hA
`define DLC_TEST_HIGH 4'hB
`endif

// ==== dlc_reg8.v ====
`default_nettype none
// Single configuration byte with write mask; masked bits always hold zero.
module dlc_reg8 #(
    parameter [7:0] RESET_VALUE = 8'h00,
    parameter [7:0] WRITE_MASK = 8'hFF
) (
    input wire sys_clk,
    input wire srst,
    input wire writeEnable,
    input wire [7:0] writeData,
    output reg [7:0] value
);
    // Read data comes straight from this register.
    always @(posedge sys_clk) begin
        if (srst) begin
            value <= RESET_VALUE & WRITE_MASK;
        end else if (writeEnable) begin
            value <= writeData & WRITE_MASK;
        end
    end
endmodule // dlc_reg8
`default_nettype wire

// ==== dlc_sync_pick.v ====
`default_nettype none
`include "dlc_consts.vh"
// Sync request source selection, registered.
module dlc_sync_pick (
    input wire sys_clk,
    input wire srst,
    input wire sourceSelect,
    input wire sync_single_ended_input,
    input wire sync_differential_input,
    output reg syncRequestN
);
    // Idle high means no sync request after reset.
    always @(posedge sys_clk) begin
        if (srst) begin
            syncRequestN <= 1'b1;
        end else begin
            syncRequestN <= sourceSelect ? sync_differential_input : sync_single_ended_input;
        end
    end
endmodule // dlc_sync_pick
`default_nettype wire

// ==== dlc_link_config_regs.v ====
`default_nettype none
`include "dlc_consts.vh"
module dlc_link_config_regs (
    input wire sys_clk,
    input wire srst,
    input wire [9:0] regAddr,
    input wire [7:0] regWriteData,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regReadData,
    input wire sync_single_ended_input,
    input wire sync_differential_input,
    output reg [3:0] decimation_select,
    output reg decimatorActive,
    output reg twosComplementOut,
    output reg final_filter_boost,
    output reg whitening_enable,
    output reg [4:0] framesPerMultiframeMinusOne,
    output reg doubleRate,
    output reg five_fourths_pll_enable,
    output reg [2:0] rateCode,
    output reg [3:0] link_test_pattern_select,
    output reg testPatternValid,
    output reg serialForceLow,
    output reg serialForceHigh,
    output reg [7:0] link_identifier_value,
    output reg [1:0] frameEndSelect,
    output reg link_enable,
    output reg linkReset,
    output reg serializerPowerDown,
    output reg linkClockGate,
    output reg syncRequestN
);
    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire [7:0] ddcReg;
    wire [7:0] lnkA;
    wire [7:0] lnkB;
    wire [7:0] didReg;
    wire [7:0] lnkC;
    wire wrDdc;
    wire wrA;
    wire wrB;
    wire wrDid;
    wire wrC;
    wire syncPicked;

    // Register selects for the write strobe.
    assign wrDdc = regWrite && (regAddr == `DLC_OFF_DDC);
    assign wrA = regWrite && (regAddr == `DLC_OFF_LNKA);
    assign wrB = regWrite && (regAddr == `DLC_OFF_LNKB);
    assign wrDid = regWrite && (regAddr == `DLC_OFF_DID);
    assign wrC = regWrite && (regAddr == `DLC_OFF_LNKC);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // reserved bits zero
    dlc_reg8 #(.RESET_VALUE(`DLC_RST_DDC), .WRITE_MASK(`DLC_DDC_MASK)) uDdc (
        .sys_clk(sys_clk), .srst(srst), .writeEnable(wrDdc), .writeData(regWriteData), .value(ddcReg));
    dlc_reg8 #(.RESET_VALUE(`DLC_RST_LNKA), .WRITE_MASK(8'hFF)) uLnkA (
        .sys_clk(sys_clk), .srst(srst), .writeEnable(wrA), .writeData(regWriteData), .value(lnkA));
    // Reserved bits 5:4 are masked so a careless write cannot disturb them.
    dlc_reg8 #(.RESET_VALUE(`DLC_RST_LNKB), .WRITE_MASK(`DLC_LNKB_MASK)) uLnkB (
        .sys_clk(sys_clk), .srst(srst), .writeEnable(wrB), .writeData(regWriteData), .value(lnkB));
    dlc_reg8 #(.RESET_VALUE(`DLC_RST_DID), .WRITE_MASK(8'hFF)) uDid (
        .sys_clk(sys_clk), .srst(srst), .writeEnable(wrDid), .writeData(regWriteData), .value(didReg));
    dlc_reg8 #(.RESET_VALUE(`DLC_RST_LNKC), .WRITE_MASK(`DLC_LNKC_MASK)) uLnkC (
        .sys_clk(sys_clk), .srst(srst), .writeEnable(wrC), .writeData(regWriteData), .value(lnkC));

    dlc_sync_pick uSync (
        .sys_clk(sys_clk),
        .srst(srst),
        .sourceSelect(lnkB[`DLC_BIT_SYNCSEL]),
        .sync_single_ended_input(sync_single_ended_input),
        .sync_differential_input(sync_differential_input),
        .syncRequestN(syncPicked)
    );

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Data valid the cycle after the strobe; unmapped addresses read zero.
    always @(posedge sys_clk) begin
        if (srst) begin
            regReadData <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                `DLC_OFF_DDC: regReadData <= ddcReg;
                `DLC_OFF_LNKA: regReadData <= lnkA;
                `DLC_OFF_LNKB: regReadData <= lnkB;
                `DLC_OFF_DID: regReadData <= didReg;
                `DLC_OFF_LNKC: regReadData <= lnkC;
                default: regReadData <= 8'h00;
            endcase
        end else begin
            regReadData <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Decoded controls
    // ----------------------------------------------------------------
    wire [3:0] mode;
    reg modeDecimates;
    reg [2:0] next_rateCode;
    assign mode = ddcReg[3:0];

    always @* begin
        case (mode)
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: modeDecimates = 1'b1;
            default: modeDecimates = 1'b0;
        endcase
    end

    // rate multiplier encoding: 0=1x, 1=2x, 2=1.25x, 3=2.5x.
    always @* begin
        next_rateCode = {1'b0, lnkB[`DLC_BIT_P54], lnkA[`DLC_BIT_DDR]};
    end

    // Outputs registered so downstream sees clean levels; the mode field changes
    // only while the link is held idle, so one cycle of lag is harmless.
    always @(posedge sys_clk) begin
        if (srst) begin
            decimation_select <= 4'h0;
            decimatorActive <= 1'b0;
            twosComplementOut <= 1'b0;
            final_filter_boost <= 1'b1;
            whitening_enable <= 1'b0;
            framesPerMultiframeMinusOne <= 5'h03;
            doubleRate <= 1'b1;
            five_fourths_pll_enable <= 1'b0;
            rateCode <= 3'h1;
            link_test_pattern_select <= 4'h0;
            testPatternValid <= 1'b1;
            serialForceLow <= 1'b0;
            serialForceHigh <= 1'b0;
            link_identifier_value <= 8'h00;
            frameEndSelect <= 2'h0;
            link_enable <= 1'b1;
            linkReset <= 1'b1;
            serializerPowerDown <= 1'b1;
            linkClockGate <= 1'b0;
            syncRequestN <= 1'b1;
        end else begin
            decimation_select <= mode;
            decimatorActive <= modeDecimates;
            twosComplementOut <= modeDecimates | ddcReg[`DLC_BIT_ENC];
            final_filter_boost <= ddcReg[`DLC_BIT_BOOST];
            whitening_enable <= lnkA[`DLC_BIT_WHITEN];
            framesPerMultiframeMinusOne <= lnkA[6:2];
            doubleRate <= lnkA[`DLC_BIT_DDR];
            five_fourths_pll_enable <= lnkB[`DLC_BIT_P54];
            rateCode <= next_rateCode;
            link_test_pattern_select <= lnkB[3:0];
            testPatternValid <= (lnkB[3:0] < 4'hC);
            serialForceLow <= (lnkB[3:0] == `DLC_TEST_LOW);
            serialForceHigh <= (lnkB[3:0] == `DLC_TEST_HIGH);
            link_identifier_value <= didReg;
            frameEndSelect <= lnkC[1:0];
            link_enable <= lnkA[`DLC_BIT_LEN];
            linkReset <= ~lnkA[`DLC_BIT_LEN];
            serializerPowerDown <= ~lnkA[`DLC_BIT_LEN];
            linkClockGate <= lnkA[`DLC_BIT_LEN];
            // Sync is held idle while the link is down.
            syncRequestN <= lnkA[`DLC_BIT_LEN] ? syncPicked : 1'b1;
        end
    end
endmodule // dlc_link_config_regs
`default_nettype wire

// ==== dlc_link_config_regs_checker.sv ====
`default_nettype none
module dlc_link_config_regs_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic regRead,
    input wire logic [7:0] regReadData,
    input wire logic [3:0] decimation_select,
    input wire logic decimatorActive,
    input wire logic twosComplementOut,
    input wire logic doubleRate,
    input wire logic five_fourths_pll_enable,
    input wire logic [2:0] rateCode,
    input wire logic [3:0] link_test_pattern_select,
    input wire logic testPatternValid,
    input wire logic serialForceLow,
    input wire logic serialForceHigh,
    input wire logic link_enable,
    input wire logic linkReset,
    input wire logic linkClockGate,
    input wire logic syncRequestN
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Derived levels against stored fields
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    chk_decim_active: assert property (
        decimatorActive == (decimation_select inside {[4'h2:4'h7]})) else $error("decimator flag wrong");
    chk_twos_decim: assert property (
        decimatorActive |-> twosComplementOut) else $error("decimated samples not twos complement");
    chk_force_low: assert property (
        serialForceLow == (link_test_pattern_select == 4'hA)) else $error("force low wrong");
    chk_force_high: assert property (
        serialForceHigh == (link_test_pattern_select == 4'hB)) else $error("force high wrong");
    chk_pattern_valid: assert property (
        testPatternValid == (link_test_pattern_select < 4'hC)) else $error("pattern valid wrong");
    chk_rate_code: assert property (
        rateCode == {1'b0, five_fourths_pll_enable, doubleRate}) else $error("rate code wrong");
    // The past terms keep the one-edge reset echo of the link controls out of view.
    chk_link_hold: assert property (
        !$past(srst) && !$past(srst, 2) && link_enable == $past(link_enable) && link_enable == $past(link_enable, 2)
        |-> linkReset == !link_enable && linkClockGate == link_enable) else $error("link hold wrong");
    chk_sync_idle: assert property (
        !link_enable [*3] |-> syncRequestN) else $error("sync request active while link off");
    chk_read_idle: assert property (
        !$past(regRead) |-> regReadData == 8'h00) else $error("read data not idle");
endmodule // dlc_link_config_regs_checker
bind dlc_link_config_regs dlc_link_config_regs_checker chk (.sys_clk(sys_clk), .srst(srst), .regRead(regRead),
    .regReadData(regReadData), .decimation_select(decimation_select), .decimatorActive(decimatorActive),
    .twosComplementOut(twosComplementOut), .doubleRate(doubleRate), .rateCode(rateCode),
    .five_fourths_pll_enable(five_fourths_pll_enable), .link_test_pattern_select(link_test_pattern_select),
    .testPatternValid(testPatternValid), .serialForceLow(serialForceLow), .serialForceHigh(serialForceHigh),
    .link_enable(link_enable), .linkReset(linkReset), .linkClockGate(linkClockGate), .syncRequestN(syncRequestN));
`default_nettype wire

// ==== dlc_link_config_regs_tb.sv ====
`default_nettype none
module dlc_link_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, srst = 1, regWrite = 0, regRead = 0, syncSe = 1, syncDf = 1;
    logic [9:0] regAddr = 0;
    logic [7:0] regWriteData = 0, rdData, idVal;
    logic [3:0] decSel, testSel;
    logic [4:0] kMinusOne;
    logic [2:0] rateCode;
    logic [1:0] frameEnd;
    logic decAct, twos, boost, whiten, ddr, p54, tpValid, fLow, fHigh, lnkEn, lnkRst, pwrDn, clkGate, syncN;
    int failures = 0, n_tests = 0;
    dlc_link_config_regs dut (.sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(rdData), .sync_single_ended_input(syncSe),
        .sync_differential_input(syncDf), .decimation_select(decSel), .decimatorActive(decAct),
        .twosComplementOut(twos), .final_filter_boost(boost), .whitening_enable(whiten),
        .framesPerMultiframeMinusOne(kMinusOne), .doubleRate(ddr), .five_fourths_pll_enable(p54),
        .rateCode(rateCode), .link_test_pattern_select(testSel), .testPatternValid(tpValid),
        .serialForceLow(fLow), .serialForceHigh(fHigh), .link_identifier_value(idVal), .frameEndSelect(frameEnd),
        .link_enable(lnkEn), .linkReset(lnkRst), .serializerPowerDown(pwrDn), .linkClockGate(clkGate),
        .syncRequestN(syncN));
    // ----------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------
    initial forever #25 sys_clk = ~sys_clk;
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Waits two more edges so the derived levels have landed before anyone looks.
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string what);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        chk(what, exp, rdData);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // A hang is cut short well beyond the few hundred cycles the tests need.
    initial begin
        repeat (4000) @(posedge sys_clk);
        failures++;
        wrap_up;
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        rd(10'h200, 8'h10, "ctrl reset");
        rd(10'h201, 8'h0F, "link a reset");
        rd(10'h202, 8'h00, "link b reset");
        rd(10'h203, 8'h00, "id reset");
        rd(10'h204, 8'h00, "link c reset");
        chk("reset levels", 8'hE4, {boost, ddr, lnkEn, rateCode, twos, p54});
        wr(10'h205, 8'hFF);
        rd(10'h205, 8'h00, "unmapped");
        $display("reset test done");
        // The link is switched off on its own before any other field of link control A moves.
        wr(10'h201, 8'h0E);
        wr(10'h201, 8'hFE);
        rd(10'h201, 8'hFE, "link a readback");
        chk("link off", 8'h1A, {lnkRst, pwrDn, clkGate, whiten, lnkEn});
        chk("frames", 8'h1F, kMinusOne);
        wr(10'h201, 8'h00);
        chk("link a clear", 8'h00, {whiten, kMinusOne, ddr});
        $display("link a test done");
        for (int d = 0; d < 16; d++) begin
            wr(10'h200, {4'hC, d[3:0]});
            rd(10'h200, {4'h0, d[3:0]}, "ctrl readback");
            chk("decim code", {4'h0, d[3:0]}, decSel);
            chk("decim flags", {6'h0, {2{d >= 2 && d <= 7}}}, {boost, twos, decAct});
        end
        wr(10'h200, 8'h30);
        chk("bypass twos", 8'h03, {twos, boost});
        $display("converter test done");
        for (int t = 0; t < 16; t++) begin
            wr(10'h202, {t[0], t[1], 2'b00, t[3:0]});
            rd(10'h202, {t[0], t[1], 2'b00, t[3:0]}, "link b readback");
            chk("test code", {4'h0, t[3:0]}, testSel);
            chk("force", {5'h0, t == 10, t == 11, t < 12}, {fLow, fHigh, tpValid});
            chk("rate", {6'h0, t[0], 1'b0}, rateCode);
        end
        wr(10'h201, 8'h02);
        wr(10'h202, 8'h80);
        chk("rate boost", 8'h03, rateCode);
        wr(10'h203, 8'hA5);
        rd(10'h203, 8'hA5, "id readback");
        chk("id", 8'hA5, idVal);
        wr(10'h204, 8'hFF);
        rd(10'h204, 8'h03, "link c readback");
        chk("frame end", 8'h03, frameEnd);
        $display("link b test done");
        wr(10'h202, 8'h00);
        wr(10'h201, 8'h0F);
        @(posedge sys_clk);
        syncSe <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("sync single", 8'h02, {clkGate, syncN});
        // Link control B may only move while the link is held off.
        wr(10'h201, 8'h0E);
        wr(10'h202, 8'h40);
        wr(10'h201, 8'h0F);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("sync diff idle", 8'h01, syncN);
        @(posedge sys_clk);
        syncDf <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("sync diff", 8'h00, syncN);
        wr(10'h201, 8'h0E);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("sync off", 8'h07, {lnkRst, pwrDn, syncN});
        $display("sync test done");
        wrap_up;
    end
endmodule // dlc_link_config_regs_tb
`default_nettype wire
